// ==== logic/lblu_defines.svh ====
// Constants of the ladder bit logic unit: word layout, sizes, reset values.
`ifndef LBLU_DEFINES_SVH
`define LBLU_DEFINES_SVH

`define LBLU_INSTR_W    16
`define LBLU_OP_MSB     15
`define LBLU_OP_LSB     12
`define LBLU_ZONE_MSB   11
`define LBLU_ZONE_LSB   9
`define LBLU_ADDR_MSB   8
`define LBLU_ADDR_LSB   0
`define LBLU_ADDR_W     9
`define LBLU_ZONE_W     3
`define LBLU_STACK_DEPTH 8
`define LBLU_COND_RST   1'h0

`endif

// ==== logic/lblu_pkg.sv ====
// Types of the ladder bit logic unit.
package lblu_pkg;

	typedef enum logic [3:0] {
		OP_LOAD       = 4'h0,
		OP_LOAD_INV   = 4'h1,
		OP_AND        = 4'h2,
		OP_AND_INV    = 4'h3,
		OP_OR         = 4'h4,
		OP_OR_INV     = 4'h5,
		OP_AND_BLK    = 4'h6,
		OP_OR_BLK     = 4'h7,
		OP_DRIVE      = 4'h8,
		OP_DRIVE_INV  = 4'h9
	} lblu_op_type;

	typedef enum logic [2:0] {
		ZN_INTERNAL   = 3'h0,
		ZN_SPECIAL    = 3'h1,
		ZN_AUX        = 3'h2,
		ZN_HOLDING    = 3'h3,
		ZN_TIMER      = 3'h4,
		ZN_LINK       = 3'h5,
		ZN_TEMP       = 3'h6,
		ZN_NONE       = 3'h7
	} lblu_zone_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EVAL = 2'h1
	} lblu_state_type;

endpackage : lblu_pkg

// ==== logic/lblu_stack.sv ====
// Last-in store of unused execution conditions.
`timescale 1ns/1ps
`include "lblu_defines.svh"

module lblu_stack #(
	parameter int DEPTH = `LBLU_STACK_DEPTH,
	parameter int AW    = $clog2(DEPTH),
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          push_i,
	input  wire logic          pop_i,
	input  wire logic          data_i,
	output logic               top_o,
	output logic [CW-1:0]      count_o
);

	logic          mem [DEPTH];
	logic [CW-1:0] count_r;
	logic          top_r;

	// The array has no reset so that it maps onto plain storage.
	always_ff @(posedge clk_i) begin
		if (push_i && (count_r < CW'(DEPTH))) begin
			mem[AW'(count_r)] <= data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= '0;
			top_r   <= 1'h0;
		end else if (push_i && (count_r < CW'(DEPTH))) begin
			count_r <= CW'(count_r + CW'(1));
			top_r   <= data_i;
		end else if (pop_i && (count_r != '0)) begin
			count_r <= CW'(count_r - CW'(1));
			top_r   <= (count_r >= CW'(2)) ?
				mem[AW'(CW'(count_r - CW'(2)))] : 1'h0;
		end
	end

	assign top_o   = top_r;
	assign count_o = count_r;

endmodule : lblu_stack

// ==== logic/lblu_unit.sv ====
// Ladder bit logic unit: condition evaluation and bit drive.
`timescale 1ns/1ps
`include "lblu_defines.svh"

// Function
// - Load starts new condition, maybe inverted.
// - Conjoin ANDs condition with bit.
// - Inverted conjoin ANDs with inverted bit.
// - Disjoin ORs condition with bit.
// - Inverted disjoin ORs with inverted bit.
// - Block ops combine current and last unused.
// - Multi-line inputs are combined as blocks.
// - Drive copies condition to designated bit.
// - Inverted drive writes inverse of condition.
// - Temp branch drive allowed mid line.
// - Zone legality per instruction form.
// - Arithmetic flags never touched.
// - First word holds operation and bit operand.
// - No limit on order or bit reuse; code refuses conjoin, disjoin and drive before the first load.
// - Fault flag on blocks execution.
module lblu_unit #(
	parameter int DEPTH = `LBLU_STACK_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       instr_valid_i,
	input  wire logic [`LBLU_INSTR_W-1:0]   instr_word_i,
	output logic                            instr_ready_o,
	output logic [`LBLU_ZONE_W-1:0]         rd_zone_o,
	output logic [`LBLU_ADDR_W-1:0]         rd_addr_o,
	input  wire logic                       rd_bit_i,
	input  wire logic                       exec_fault_i,
	output logic                            wr_en_o,
	output logic [`LBLU_ZONE_W-1:0]         wr_zone_o,
	output logic [`LBLU_ADDR_W-1:0]         wr_addr_o,
	output logic                            wr_data_o,
	output logic                            cond_o,
	output logic                            done_o,
	output logic                            illegal_o,
	output logic                            skipped_o
);

	typedef struct packed {
		lblu_pkg::lblu_state_type state;
		lblu_pkg::lblu_op_type    op;
		lblu_pkg::lblu_zone_type  zone;
		logic [`LBLU_ADDR_W-1:0]  addr;
		logic                     ready;
		logic                     cond;
		logic                     has_cond;
		logic                     wr_en;
		logic                     wr_data;
		logic                     done;
		logic                     illegal;
		logic                     skipped;
	} lblu_regs_type;

	lblu_regs_type s_r;
	lblu_regs_type s_nxt;
	logic          push;
	logic          pop;
	logic          stk_top;
	logic [CW-1:0] stk_count;
	logic          bit_val;

	// Temp branch bits feed only plain load and plain drive.
	function automatic logic zone_ok(input lblu_pkg::lblu_op_type op,
		input lblu_pkg::lblu_zone_type zone);
		if (op == lblu_pkg::OP_AND_BLK || op == lblu_pkg::OP_OR_BLK) begin
			return 1'h1;
		end
		if (zone == lblu_pkg::ZN_NONE) begin
			return 1'h0;
		end
		if (zone == lblu_pkg::ZN_TEMP) begin
			return op == lblu_pkg::OP_LOAD || op == lblu_pkg::OP_DRIVE;
		end
		return 1'h1;
	endfunction : zone_ok

	function automatic logic is_inv(input lblu_pkg::lblu_op_type op);
		return op == lblu_pkg::OP_LOAD_INV || op == lblu_pkg::OP_AND_INV ||
			op == lblu_pkg::OP_OR_INV || op == lblu_pkg::OP_DRIVE_INV;
	endfunction : is_inv

	lblu_stack #(
		.DEPTH   (DEPTH)
	) u_stack (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.push_i  (push),
		.pop_i   (pop),
		.data_i  (s_r.cond),
		.top_o   (stk_top),
		.count_o (stk_count)
	);

	assign bit_val = rd_bit_i ^ is_inv(s_r.op);

	always_comb begin
		s_nxt         = s_r;
		s_nxt.wr_en   = 1'h0;
		s_nxt.done    = 1'h0;
		s_nxt.illegal = 1'h0;
		s_nxt.skipped = 1'h0;
		push          = 1'h0;
		pop           = 1'h0;
		unique case (s_r.state)
			lblu_pkg::ST_IDLE: begin
				s_nxt.ready = 1'h1;
				if (instr_valid_i && s_r.ready) begin
					s_nxt.op    = lblu_pkg::lblu_op_type'(
						instr_word_i[`LBLU_OP_MSB:`LBLU_OP_LSB]);
					s_nxt.zone  = lblu_pkg::lblu_zone_type'(
						instr_word_i[`LBLU_ZONE_MSB:`LBLU_ZONE_LSB]);
					s_nxt.addr  = instr_word_i[`LBLU_ADDR_MSB:`LBLU_ADDR_LSB];
					s_nxt.ready = 1'h0;
					s_nxt.state = lblu_pkg::ST_EVAL;
				end
			end
			lblu_pkg::ST_EVAL: begin
				s_nxt.state = lblu_pkg::ST_IDLE;
				s_nxt.ready = 1'h1;
				s_nxt.done  = 1'h1;
				if (exec_fault_i) begin
					s_nxt.skipped = 1'h1;
				end else if (!zone_ok(s_r.op, s_r.zone)) begin
					s_nxt.illegal = 1'h1;
				end else begin
					case (s_r.op)
						lblu_pkg::OP_LOAD, lblu_pkg::OP_LOAD_INV: begin
							if (s_r.has_cond && stk_count == CW'(DEPTH)) begin
								s_nxt.illegal = 1'h1;
							end else begin
								push           = s_r.has_cond;
								s_nxt.cond     = bit_val;
								s_nxt.has_cond = 1'h1;
							end
						end
						lblu_pkg::OP_AND, lblu_pkg::OP_AND_INV: begin
							if (s_r.has_cond) begin
								s_nxt.cond = s_r.cond & bit_val;
							end else begin
								s_nxt.illegal = 1'h1;
							end
						end
						lblu_pkg::OP_OR, lblu_pkg::OP_OR_INV: begin
							// A refused disjoin must not raise the condition.
							if (s_r.has_cond) begin
								s_nxt.cond = s_r.cond | bit_val;
							end else begin
								s_nxt.illegal = 1'h1;
							end
						end
						lblu_pkg::OP_AND_BLK, lblu_pkg::OP_OR_BLK: begin
							if (stk_count == '0 || !s_r.has_cond) begin
								s_nxt.illegal = 1'h1;
							end else begin
								pop        = 1'h1;
								s_nxt.cond = (s_r.op == lblu_pkg::OP_AND_BLK) ?
									(s_r.cond & stk_top) : (s_r.cond | stk_top);
							end
						end
						lblu_pkg::OP_DRIVE, lblu_pkg::OP_DRIVE_INV: begin
							s_nxt.wr_en   = s_r.has_cond;
							s_nxt.wr_data = s_r.cond ^ is_inv(s_r.op);
							s_nxt.illegal = !s_r.has_cond;
						end
						default: begin
							s_nxt.illegal = 1'h1;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r       <= '0;
			s_r.cond  <= `LBLU_COND_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign instr_ready_o = s_r.ready;
	assign rd_zone_o     = s_r.zone;
	assign rd_addr_o     = s_r.addr;
	assign wr_en_o       = s_r.wr_en;
	assign wr_zone_o     = s_r.zone;
	assign wr_addr_o     = s_r.addr;
	assign wr_data_o     = s_r.wr_data;
	assign cond_o        = s_r.cond;
	assign done_o        = s_r.done;
	assign illegal_o     = s_r.illegal;
	assign skipped_o     = s_r.skipped;

	// Checks compare against the decoded operation held during evaluation.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic ev;
	assign ev = s_r.state == lblu_pkg::ST_EVAL && !exec_fault_i &&
		zone_ok(s_r.op, s_r.zone);

	sequence take_seq;
		instr_valid_i && instr_ready_o;
	endsequence
	sequence finish_seq;
		!instr_ready_o ##1 (done_o && instr_ready_o);
	endsequence

	chk_take_to_done: assert property (take_seq |=> finish_seq)
		else $error("Instruction did not finish two cycles after take.");
	chk_load_value: assert property (
		ev && (s_r.op == lblu_pkg::OP_LOAD ||
		s_r.op == lblu_pkg::OP_LOAD_INV) |=> illegal_o ||
		cond_o == ($past(rd_bit_i) ^ $past(s_r.op[0])))
		else $error("Load did not set condition from bit.");
	chk_conjoin_inv: assert property (
		ev && s_r.op == lblu_pkg::OP_AND_INV && s_r.has_cond |=>
		cond_o == ($past(s_r.cond) & !$past(rd_bit_i)))
		else $error("Inverted conjoin result wrong.");
	chk_disjoin_val: assert property (
		ev && s_r.op == lblu_pkg::OP_OR && s_r.has_cond |=>
		cond_o == ($past(s_r.cond) | $past(rd_bit_i)))
		else $error("Disjoin result wrong.");
	chk_drive_value: assert property (
		ev && s_r.has_cond && s_r.op == lblu_pkg::OP_DRIVE_INV |=>
		wr_en_o && wr_data_o == !$past(s_r.cond) && $stable(cond_o))
		else $error("Inverted drive wrote wrong value.");
	chk_fault_skip: assert property (
		s_r.state == lblu_pkg::ST_EVAL && exec_fault_i |=>
		skipped_o && !wr_en_o && $stable(cond_o))
		else $error("Instruction executed while fault flag on.");
	chk_temp_zone: assert property (
		s_r.state == lblu_pkg::ST_EVAL && !exec_fault_i &&
		s_r.zone == lblu_pkg::ZN_TEMP && !(s_r.op inside {
		lblu_pkg::OP_LOAD, lblu_pkg::OP_DRIVE, lblu_pkg::OP_AND_BLK,
		lblu_pkg::OP_OR_BLK}) |=> illegal_o && $stable(cond_o))
		else $error("Temp branch zone accepted by a condition form.");
	chk_push_load: assert property (
		ev && s_r.op == lblu_pkg::OP_LOAD &&
		s_r.has_cond && stk_count < CW'(DEPTH) |=>
		stk_count == CW'($past(stk_count) + CW'(1)) &&
		stk_top == $past(s_r.cond))
		else $error("Load did not store prior condition.");
	chk_block_and: assert property (
		ev && s_r.op == lblu_pkg::OP_AND_BLK &&
		s_r.has_cond && stk_count != '0 |=>
		cond_o == ($past(s_r.cond) & $past(stk_top)) &&
		stk_count == CW'($past(stk_count) - CW'(1)))
		else $error("Block conjoin wrong or store not popped.");

endmodule : lblu_unit

// ==== dv/tb_ladder_bit_logic_unit.sv ====
// Self-checking bench of the ladder bit logic unit.
`timescale 1ns/1ps
`include "lblu_defines.svh"

module tb_ladder_bit_logic_unit;
	logic                      clk_i         = 1'h0;
	logic                      rst_n_i       = 1'h0;
	logic                      instr_valid_i = 1'h0;
	logic [`LBLU_INSTR_W-1:0]  instr_word_i  = 16'h0000;
	logic                      rd_bit_i      = 1'h0;
	logic                      exec_fault_i  = 1'h0;
	logic                      instr_ready_o;
	logic [`LBLU_ZONE_W-1:0]   rd_zone_o;
	logic [`LBLU_ADDR_W-1:0]   rd_addr_o;
	logic                      wr_en_o;
	logic [`LBLU_ZONE_W-1:0]   wr_zone_o;
	logic [`LBLU_ADDR_W-1:0]   wr_addr_o;
	logic                      wr_data_o;
	logic                      cond_o;
	logic                      done_o;
	logic                      illegal_o;
	logic                      skipped_o;
	int                        fail_count = 0;
	int                        compares   = 0;
	logic [22:0]               rows [17];
	logic [4:0]                got;

	lblu_unit uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
		.instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
		.rd_zone_o(rd_zone_o), .rd_addr_o(rd_addr_o), .rd_bit_i(rd_bit_i),
		.exec_fault_i(exec_fault_i), .wr_en_o(wr_en_o),
		.wr_zone_o(wr_zone_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .cond_o(cond_o), .done_o(done_o),
		.illegal_o(illegal_o), .skipped_o(skipped_o)
	);

	always #50 clk_i = ~clk_i;

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic check(logic [8:0] seen, logic [8:0] exp, string what);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : check

	// Result bits are condition, write, write data, refused, skipped.
	task automatic run(logic [15:0] w, logic b, logic f,
			output logic [4:0] res);
		int n;
		n = 0;
		@(posedge clk_i);
		instr_valid_i <= 1'h1;
		instr_word_i  <= w;
		rd_bit_i      <= b;
		exec_fault_i  <= f;
		do begin
			@(posedge clk_i);
			n++;
		end while (instr_ready_o !== 1'h1 && n < 20);
		instr_valid_i <= 1'h0;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (done_o !== 1'h1 && n < 20);
		res = {cond_o, wr_en_o, wr_data_o, illegal_o, skipped_o};
		check(9'(n), 9'h001, "answer latency");
	endtask : run

	function automatic logic [22:0] row(logic [3:0] op, logic [2:0] zn,
			logic [8:0] ad, logic b, logic f, logic [4:0] e);
		return {op, zn, ad, b, f, e};
	endfunction : row

	initial begin
		#200000;
		fail_count++;
		complete_run();
	end

	initial begin
		rows = '{row(4'h2, 3'h0, 9'h001, 1'h1, 1'h0, 5'h02),
			row(4'h0, 3'h0, 9'h001, 1'h1, 1'h0, 5'h10),
			row(4'h2, 3'h1, 9'h001, 1'h0, 1'h0, 5'h00),
			row(4'h5, 3'h2, 9'h002, 1'h0, 1'h0, 5'h10),
			row(4'h3, 3'h3, 9'h001, 1'h0, 1'h0, 5'h10),
			row(4'h1, 3'h4, 9'h003, 1'h1, 1'h0, 5'h00),
			row(4'h4, 3'h5, 9'h003, 1'h1, 1'h0, 5'h10),
			row(4'h6, 3'h7, 9'h000, 1'h0, 1'h0, 5'h10),
			row(4'h6, 3'h7, 9'h000, 1'h0, 1'h0, 5'h12),
			row(4'h8, 3'h6, 9'h005, 1'h0, 1'h0, 5'h1C),
			row(4'h9, 3'h3, 9'h1FF, 1'h0, 1'h0, 5'h18),
			row(4'h2, 3'h6, 9'h005, 1'h1, 1'h0, 5'h12),
			row(4'h0, 3'h0, 9'h001, 1'h0, 1'h1, 5'h11),
			row(4'h0, 3'h0, 9'h001, 1'h0, 1'h0, 5'h00),
			row(4'h7, 3'h7, 9'h000, 1'h0, 1'h0, 5'h10),
			row(4'hF, 3'h0, 9'h001, 1'h0, 1'h0, 5'h12),
			row(4'h1, 3'h7, 9'h001, 1'h0, 1'h0, 5'h12)};
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		foreach (rows[i]) begin
			run(rows[i][22:7], rows[i][6], rows[i][5], got);
			// Write data only matters when a write is expected.
			if (rows[i][3] !== 1'h1) begin
				got[2] = rows[i][2];
			end
			check(9'(got), 9'(rows[i][4:0]), "row result");
			check(rd_addr_o, rows[i][15:7], "read addr");
			check(9'(rd_zone_o), 9'(rows[i][18:16]), "rd zone");
			if (rows[i][3] === 1'h1) begin
				check(wr_addr_o, rows[i][15:7], "drive addr");
				check(9'(wr_zone_o), 9'(rows[i][18:16]), "zone");
			end
		end
		$display("row walk done");
		// Eight pushes fill the store, next load refused.
		for (int i = 0; i < 10; i++) begin
			run({4'h0, 3'h0, 9'(i)}, i < 8, 1'h0, got);
			check(9'(got), (i < 8) ? 9'h010 : 9'h012, "store fill");
		end
		// Block ops pop and combine until the store runs dry.
		for (int j = 0; j < 9; j++) begin
			run({4'h7, 3'h7, 9'h000}, 1'h0, 1'h0, got);
			check(9'(got), (j < 8) ? 9'h010 : 9'h012, "pop");
		end
		$display("store test done");
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		@(posedge clk_i);
		#1;
		check(9'({cond_o, instr_ready_o, done_o}), 9'h000, "rst");
		@(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		#1;
		check(9'(instr_ready_o), 9'h001, "ready after reset");
		// After reset the store is empty, so block op is refused.
		run({4'h6, 3'h7, 9'h000}, 1'h0, 1'h0, got);
		check(9'(got), 9'h002, "empty after reset");
		run({4'h4, 3'h0, 9'h001}, 1'h1, 1'h0, got);
		check(9'(got), 9'h002, "or without condition");
		$display("reset test done");
		complete_run();
	end
endmodule : tb_ladder_bit_logic_unit
